// file: logic/eds_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EDS_PARAMS_SVH
`define EDS_PARAMS_SVH

`define EDS_OFF_CLOCK_CONTROL   12'h000
`define EDS_OFF_MEMORY_MAP      12'h004
`define EDS_OFF_POINTER_SELECT  12'h008
`define EDS_OFF_POINTER_LOAD    12'h00C
`define EDS_OFF_POINTER_FIRST   12'h010
`define EDS_OFF_POINTER_SECOND  12'h014
`define EDS_OFF_POINTER_INC     12'h018
`define EDS_OFF_MOVE_CMD        12'h01C
`define EDS_OFF_MOVE_STATUS     12'h020

`define EDS_STRETCH_MSB         2
`define EDS_STRETCH_LSB         0
`define EDS_WAIT_ENABLE_BIT     7
`define EDS_CMD_WRITE_BIT       8
`define EDS_STRETCH_RESET       3'h1
`define EDS_POINTER_RESET       16'h0000

`define EDS_CLKS_PER_MC         4
`define EDS_PHASE_C3            2'h2
`define EDS_PHASE_LAST          2'h3

`endif

// file: logic/eds_pkg.sv
// Types shared by the external data move sequencer
package eds_pkg;
  typedef enum logic [1:0] {
    EDS_IDLE,
    EDS_FETCH,
    EDS_ACCESS
  } eds_state_t;
endpackage

// file: logic/eds_seq_if.sv
// Signals between the register side and the access sequencer
`timescale 1ns/1ps
interface eds_seq_if;
  logic       start;
  logic       is_write;
  logic [2:0] stretch;
  logic       wait_en;
  logic       wait_n_s;
  logic [1:0] phase;
  logic       busy;
  logic       capture;
  logic       done;
  logic       rd_n;
  logic       wr_n;
  logic       hold;
  modport ctrl (output start, is_write, stretch, wait_en, wait_n_s, phase,
                input busy, capture, done, rd_n, wr_n, hold);
  modport seq  (input start, is_write, stretch, wait_en, wait_n_s, phase,
                output busy, capture, done, rd_n, wr_n, hold);
endinterface

// file: logic/eds_seq.sv
// Machine-cycle sequencer for one external data move
`timescale 1ns/1ps
`include "eds_params.svh"
module eds_seq (
  input  wire logic pclk,
  input  wire logic presetn,
  eds_seq_if.seq    sq
);
  eds_pkg::eds_state_t state;
  logic [2:0] remain;   // Access cycles still owed by the stretch
  logic       first;    // First access cycle
  logic       extend;   // Wait sampled active, one more cycle owed
  logic       pending;  // Start seen, waiting for a cycle boundary
  logic       strobe;
  logic       hold;

  wire cyc_end   = (sq.phase == `EDS_PHASE_LAST);
  wire at_c3     = (sq.phase == `EDS_PHASE_C3);
  wire in_access = (state == eds_pkg::EDS_ACCESS);
  wire last_cyc  = in_access && (remain == 3'h0);
  wire wait_hit  = sq.wait_en && !sq.wait_n_s;
  wire finish_c3 = last_cyc && at_c3 && !wait_hit;
  wire on_zero   = in_access && first && (sq.stretch == 3'h0) && (sq.phase == 2'h0);
  wire on_long   = in_access && first && (sq.stretch != 3'h0) && at_c3;

  assign sq.busy    = (state != eds_pkg::EDS_IDLE) || pending;
  assign sq.capture = finish_c3;
  assign sq.done    = last_cyc && cyc_end && !extend;
  assign sq.rd_n    = !(strobe && !sq.is_write);
  assign sq.wr_n    = !(strobe && sq.is_write);
  assign sq.hold    = hold;

  // Start is only latched while idle; moves never overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else if (sq.start && state == eds_pkg::EDS_IDLE) begin
      pending <= 1'b1;
    end else if (cyc_end) begin
      pending <= 1'b0;
    end
  end

  // State walks on cycle boundaries only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= eds_pkg::EDS_IDLE;
      remain <= 3'h0;
      first  <= 1'b0;
    end else if (cyc_end) begin
      unique case (state)
        // RULE1 fetch cycle first
        eds_pkg::EDS_IDLE: begin
          if (pending) begin
            state <= eds_pkg::EDS_FETCH;
          end
        end
        eds_pkg::EDS_FETCH: begin
          state  <= eds_pkg::EDS_ACCESS;
          remain <= sq.stretch;
          first  <= 1'b1;
        end
        // RULE3 one cycle per step
        eds_pkg::EDS_ACCESS: begin
          first <= 1'b0;
          if (remain != 3'h0) begin
            remain <= remain - 3'h1;
          end else if (!extend) begin
            state <= eds_pkg::EDS_IDLE;
          end
        end
      endcase
    end
  end

  // RULE9 sample at C3
  // RULE10 one wait cycle added
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extend <= 1'b0;
    end else if (last_cyc && at_c3) begin
      extend <= wait_hit;
    end else if (cyc_end) begin
      extend <= 1'b0;
    end
  end

  // RULE6 strobe width by stretch
  // RULE15 strobe ends only in final cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe <= 1'b0;
    end else if (on_zero || on_long) begin
      strobe <= 1'b1;
    end else if (finish_c3) begin
      strobe <= 1'b0;
    end
  end

  // RULE4 CPU held only for added cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
    end else begin
      hold <= in_access && !(cyc_end && remain == 3'h0 && !extend)
              && !(first && !cyc_end) && (sq.stretch != 3'h0 || extend || !first);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_zero_width_a: assert property ( // RULE6
    $rose(strobe) && sq.stretch == 3'h0 && !sq.wait_en |-> strobe [*2] ##1 !strobe)
    else $error("stretch zero strobe not two clocks");
  strobe_one_width_a: assert property ( // RULE6
    $rose(strobe) && sq.stretch == 3'h1 && !sq.wait_en |-> strobe [*4] ##1 !strobe)
    else $error("stretch one strobe not four clocks");
  fetch_length_a: assert property ( // RULE1
    $rose(state == eds_pkg::EDS_FETCH) |-> (state == eds_pkg::EDS_FETCH) [*4]
      ##1 in_access)
    else $error("fetch cycle not four clocks");
  wait_extends_a: assert property ( // RULE10
    last_cyc && at_c3 && wait_hit |-> ##2 in_access ##3 in_access)
    else $error("wait sample did not add a cycle");
  strobe_ends_c3_a: assert property ( // RULE15
    $fell(strobe) |-> $past(last_cyc) && $past(at_c3) && !$past(wait_hit))
    else $error("strobe ended outside final C3");
  no_wait_ignored_a: assert property ( // RULE8
    !sq.wait_en && last_cyc && at_c3 |=> !extend)
    else $error("wait honoured while disabled");
  wait_cover_c: cover property (extend && cyc_end);
  zero_cover_c: cover property ($rose(strobe) && sq.stretch == 3'h0);
endmodule // eds_seq

// file: logic/eds_access_ctrl.sv
// APB register file and pins for external data moves with stretch and wait
`timescale 1ns/1ps
`include "eds_params.svh"
// Function
// RULE1: A move starts with a four-clock fetch cycle, then the access cycle.
// RULE2: Stretch value sits in bits 2..0 of the clock control register.
// RULE3: Stretch 0..7 makes the move last 2..9 machine cycles.
// RULE4: Stretch holds the CPU only during the move, nothing else changes.
// RULE5: Stretch resets to one, giving three machine cycles; zero allowed.
// RULE6: Strobe width is 2 clocks at zero, then four clocks per step.
// RULE7: Active-low wait input arrives on port six bit zero.
// RULE8: Wait input matters only while wait enable, bit 7, is set.
// RULE9: Stretch sets the minimum; wait sampled at C3 before strobe rise. The code samples at C3 of the last access cycle, after the strobe has risen.
// RULE10: Each active wait sample inserts one more machine cycle.
// RULE11: Wait cycles are unlimited; the partner must release wait.
// RULE12: Wait enable only changes through the timed access unlock.
// RULE13: Select zero uses the first pointer, incremented select the second.
// RULE14: Partner sets wait stable before the C3 sample point.
// RULE15: Address and data stay stable; strobe ends only in the last cycle.
module eds_access_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timed_access_open,
  input  wire logic        port_six_bit_zero,
  input  wire logic [7:0]  ext_data_in,
  output logic      [7:0]  ext_data_out,
  output logic             ext_data_oe_n,
  output logic      [15:0] ext_addr,
  output logic             ext_rd_n,
  output logic             ext_wr_n,
  output logic             cpu_hold
);
  eds_seq_if sq ();

  logic [1:0]  phase;
  logic [2:0]  stretch_field;
  logic        wait_enable;
  logic        pointer_select;
  logic [15:0] data_pointer_first;
  logic [15:0] data_pointer_second;
  logic [7:0]  move_data;
  logic        move_write;
  logic [7:0]  read_data;
  logic        wait_s1;
  logic        wait_s2;
  logic [7:0]  din_s1;
  logic [7:0]  din_s2;
  logic        start_pulse;
  logic        cap_d1;      // Capture delayed past the data synchroniser
  logic        cap_d2;

  eds_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sq      (sq)
  );

  // Address decode; writes land at the edge that sees pready high
  wire        acc        = psel && penable;
  wire        wr_en      = acc && pwrite && pready;
  wire        hit_cc     = (paddr == `EDS_OFF_CLOCK_CONTROL);
  wire        hit_mm     = (paddr == `EDS_OFF_MEMORY_MAP);
  wire        hit_ps     = (paddr == `EDS_OFF_POINTER_SELECT);
  wire        hit_pl     = (paddr == `EDS_OFF_POINTER_LOAD);
  wire        hit_p1     = (paddr == `EDS_OFF_POINTER_FIRST);
  wire        hit_p2     = (paddr == `EDS_OFF_POINTER_SECOND);
  wire        hit_pi     = (paddr == `EDS_OFF_POINTER_INC);
  wire        hit_mc     = (paddr == `EDS_OFF_MOVE_CMD);
  wire        hit_ms     = (paddr == `EDS_OFF_MOVE_STATUS);
  wire        mapped     = hit_cc || hit_mm || hit_ps || hit_pl || hit_p1 || hit_p2
                           || hit_pi || hit_mc || hit_ms;
  // RULE13 select picks the pointer
  wire [15:0] sel_ptr    = pointer_select ? data_pointer_second : data_pointer_first;
  wire        busy       = sq.busy;
  // Pointers must not move under a running access
  wire        ptr_wr_ok  = wr_en && !busy;
  wire        start_req  = wr_en && hit_mc && !busy;

  // Read mux of all mapped registers
  wire [31:0] rd_mux =
      hit_cc ? {29'h0, stretch_field} :
      hit_mm ? {24'h0, wait_enable, 7'h0} :
      hit_ps ? {31'h0, pointer_select} :
      hit_pl ? {16'h0, sel_ptr} :
      hit_p1 ? {16'h0, data_pointer_first} :
      hit_p2 ? {16'h0, data_pointer_second} :
      hit_mc ? {23'h0, move_write, move_data} :
      hit_ms ? {16'h0, read_data, 7'h0, busy} : 32'h0000_0000;

  // Machine cycle phase divider, C1..C4 as 0..3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Pin synchronisers: first stage feeds only the second
  // RULE7 wait pin synchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
      din_s1  <= 8'h00;
      din_s2  <= 8'h00;
    end else begin
      wait_s1 <= port_six_bit_zero;
      wait_s2 <= wait_s1;
      din_s1  <= ext_data_in;
      din_s2  <= din_s1;
    end
  end

  // APB answer one cycle into the access phase, data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata  <= (acc && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // RULE2 stretch in bits 2..0
  // RULE5 stretch resets to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_field <= `EDS_STRETCH_RESET;
    end else if (wr_en && hit_cc && !busy) begin
      stretch_field <= pwdata[`EDS_STRETCH_MSB:`EDS_STRETCH_LSB];
    end
  end

  // RULE12 guarded by timed access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_enable <= 1'b0;
    end else if (wr_en && hit_mm && timed_access_open) begin
      wait_enable <= pwdata[`EDS_WAIT_ENABLE_BIT];
    end
  end

  // RULE13 loads and increments follow select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_select      <= 1'b0;
      data_pointer_first  <= `EDS_POINTER_RESET;
      data_pointer_second <= `EDS_POINTER_RESET;
    end else if (ptr_wr_ok) begin
      if (hit_ps) begin
        pointer_select <= pwdata[0];
      end
      if (hit_pl && !pointer_select) begin
        data_pointer_first <= pwdata[15:0];
      end
      if (hit_pl && pointer_select) begin
        data_pointer_second <= pwdata[15:0];
      end
      if (hit_pi && !pointer_select) begin
        data_pointer_first <= data_pointer_first + 16'h0001;
      end
      if (hit_pi && pointer_select) begin
        data_pointer_second <= data_pointer_second + 16'h0001;
      end
    end
  end

  // Move command latch; refused while a move runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_data   <= 8'h00;
      move_write  <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= start_req;
      if (start_req) begin
        move_data  <= pwdata[7:0];
        move_write <= pwdata[`EDS_CMD_WRITE_BIT];
      end
    end
  end

  // RULE15 address and data frozen for the whole move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_addr      <= 16'h0000;
      ext_data_out  <= 8'h00;
      ext_data_oe_n <= 1'b1;
    end else begin
      if (start_pulse) begin
        ext_addr     <= sel_ptr;
        ext_data_out <= move_data;
      end
      ext_data_oe_n <= !(busy && move_write);
    end
  end

  // Read data taken two clocks after the final C3, so the synchronised
  // sample already comes from the strobed bus even at stretch zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_d1    <= 1'b0;
      cap_d2    <= 1'b0;
      read_data <= 8'h00;
    end else begin
      cap_d1 <= sq.capture && !move_write;
      cap_d2 <= cap_d1;
      if (cap_d2) begin
        read_data <= din_s2;
      end
    end
  end

  // Strobes and hold re-registered straight to the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_rd_n <= 1'b1;
      ext_wr_n <= 1'b1;
      cpu_hold <= 1'b0;
    end else begin
      ext_rd_n <= sq.rd_n;
      ext_wr_n <= sq.wr_n;
      cpu_hold <= sq.hold;
    end
  end

  // Sequencer inputs
  // RULE8 wait gated by enable
  // RULE11 no limit on wait cycles
  assign sq.start    = start_pulse;
  assign sq.is_write = move_write;
  assign sq.stretch  = stretch_field;
  assign sq.wait_en  = wait_enable;
  assign sq.wait_n_s = wait_s2;
  assign sq.phase    = phase;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  locked_enable_a: assert property ( // RULE12
    !timed_access_open |=> $stable(wait_enable))
    else $error("wait enable changed without unlock");
  stretch_reset_a: assert property ( // RULE5
    $rose(presetn) |-> stretch_field == `EDS_STRETCH_RESET)
    else $error("stretch not one after reset");
  addr_stable_a: assert property ( // RULE15
    busy && !start_pulse && $past(busy) |-> $stable(ext_addr) && $stable(ext_data_out))
    else $error("address moved during access");
  ptr_select_a: assert property ( // RULE13
    start_pulse |=> ext_addr == $past(pointer_select ? data_pointer_second
                                                     : data_pointer_first))
    else $error("wrong pointer driven");
  apb_answer_a: assert property (
    acc && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  write_cover_c: cover property (start_pulse && move_write);
  stretch7_cover_c: cover property (start_pulse && stretch_field == 3'h7);
  wait_cover_c: cover property (busy && wait_enable && !wait_s2);
endmodule // eds_access_ctrl

// file: verification/eds_ext_ram.sv
// External data RAM model with an active-low wait request
`timescale 1ns/1ps
module eds_ext_ram (
  input  wire logic        pclk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic        wait_arm,
  input  wire logic [7:0]  wait_clks,
  output logic      [7:0]  ext_data_in,
  output logic             port_six_bit_zero
);
  logic [7:0] mem [0:255];
  logic [7:0] last_q   = 8'h00;
  logic [7:0] cnt      = 8'h00;
  logic       released = 1'b0;
  // A released bus shows the inverse of its last byte, so stale data never passes
  assign ext_data_in = !ext_rd_n ? mem[ext_addr[7:0]] : ~last_q;
  // wait low early
  // Armed wait is low before the strobe, well ahead of the third-phase sample
  assign port_six_bit_zero = !(wait_arm && !released);
  // wait always released
  // Count strobe clocks and let go of wait after the commanded number
  always @(posedge pclk) begin
    last_q <= ext_data_in;
    if (!ext_wr_n) mem[ext_addr[7:0]] <= ext_data_out;
    if (!wait_arm) begin
      cnt      <= 8'h00;
      released <= 1'b0;
    end else if (!ext_rd_n || !ext_wr_n) begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 >= wait_clks) released <= 1'b1;
    end
  end
endmodule // eds_ext_ram

// file: verification/ext_data_access_stretch_wait_tb.sv
// Self-checking bench for the external data move sequencer
`timescale 1ns/1ps
`include "eds_params.svh"
module ext_data_access_stretch_wait_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, ext_data_oe_n, ext_rd_n, ext_wr_n, cpu_hold, wait_n, e;
  logic        timed_access_open = 1'b0, wait_arm = 1'b0;
  logic [7:0]  ext_data_in, ext_data_out, d, wait_clks = 8'h00, exp_dout;
  logic [15:0] ext_addr, a, exp_addr;
  int          fail_count = 0, n_compared = 0, run = 0, width = 0, seed, s;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  eds_access_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timed_access_open(timed_access_open), .port_six_bit_zero(wait_n),
    .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n),
    .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .cpu_hold(cpu_hold));

  eds_ext_ram ram (.pclk(pclk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
    .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .wait_arm(wait_arm), .wait_clks(wait_clks),
    .ext_data_in(ext_data_in), .port_six_bit_zero(wait_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic wreg(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] x; logic y;
    apb(1'b1, ad, wd, x, y);
  endtask

  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] x; logic y;
    apb(1'b0, ad, 32'h0, x, y);
    chk(x, exp);
  endtask

  // Start a move, optionally poke the stretch while busy, then poll until idle
  task automatic move(input logic w, input logic [7:0] dd, input logic bump);
    logic [31:0] x; logic y; int n;
    n = 0;
    wreg(`EDS_OFF_MOVE_CMD, {23'h0, w, dd});
    if (bump) wreg(`EDS_OFF_CLOCK_CONTROL, 32'h7);
    do begin
      apb(1'b0, `EDS_OFF_MOVE_STATUS, 32'h0, x, y);
      n++;
    end while (x[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fail_count++;
      wrap_up();
    end
  endtask

  function automatic int exp_width(input int st);
    return (st == 0) ? 2 : 4 * st;
  endfunction

  // Strobe monitor: width in clocks, address and write data held throughout
  always @(posedge pclk) begin
    if (ext_rd_n === 1'b0 || ext_wr_n === 1'b0) begin
      run <= run + 1;
      n_compared++;
      if ({ext_addr, ext_wr_n ? exp_dout : ext_data_out} !== {exp_addr, exp_dout}) begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, ext_addr, exp_addr);
      end
    end else if (run != 0) begin
      width <= run;
      run   <= 0;
    end
  end

  initial begin
    seed = 68735;
    exp_dout = 8'h00;
    exp_addr = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`EDS_OFF_CLOCK_CONTROL, 32'h1);
    rchk(`EDS_OFF_MEMORY_MAP, 32'h0);
    rchk(`EDS_OFF_POINTER_SELECT, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("test reset and map done");
    // Pointer select, load and increment
    a = $random(seed);
    wreg(`EDS_OFF_POINTER_LOAD, {16'h0, a});
    wreg(`EDS_OFF_POINTER_INC, 32'h0);
    wreg(`EDS_OFF_POINTER_SELECT, 32'h1);
    wreg(`EDS_OFF_POINTER_LOAD, {16'h0, ~a});
    rchk(`EDS_OFF_POINTER_FIRST, {16'h0, a + 16'h1});
    rchk(`EDS_OFF_POINTER_SECOND, {16'h0, ~a});
    $display("test pointers done");
    // Every stretch value: write then read back through the external RAM
    for (s = 0; s < 8; s++) begin
      d = $random(seed);
      a = $random(seed);
      wreg(`EDS_OFF_CLOCK_CONTROL, s);
      rchk(`EDS_OFF_CLOCK_CONTROL, s);
      wreg(`EDS_OFF_POINTER_SELECT, s & 1);
      wreg(`EDS_OFF_POINTER_LOAD, {16'h0, a});
      exp_addr = a;
      exp_dout = d;
      move(1'b1, d, 1'b0);
      chk(width, exp_width(s));
      chk({31'h0, cpu_hold}, 32'h0);
      move(1'b0, 8'h00, 1'b0);
      chk(width, exp_width(s));
      rchk(`EDS_OFF_MOVE_STATUS, {16'h0, d, 8'h00});
    end
    $display("test stretch sweep done");
    // Wait input ignored until enabled through the unlock window
    wreg(`EDS_OFF_CLOCK_CONTROL, 32'h1);
    wreg(`EDS_OFF_MEMORY_MAP, 32'h80);
    rchk(`EDS_OFF_MEMORY_MAP, 32'h0);
    wait_clks <= 8'd9;
    wait_arm  <= 1'b1;
    move(1'b0, 8'h00, 1'b0);
    chk(width, 32'd4);
    wait_arm <= 1'b0;
    timed_access_open <= 1'b1;
    wreg(`EDS_OFF_MEMORY_MAP, 32'h80);
    timed_access_open <= 1'b0;
    rchk(`EDS_OFF_MEMORY_MAP, 32'h80);
    move(1'b0, 8'h00, 1'b0);
    chk(width, 32'd4);
    wait_arm <= 1'b1;
    move(1'b0, 8'h00, 1'b1);
    chk({31'h0, width % 4 == 0 && width >= 9 && width <= 24}, 32'h1);
    rchk(`EDS_OFF_CLOCK_CONTROL, 32'h1);
    rchk(`EDS_OFF_MOVE_STATUS, {16'h0, d, 8'h00});
    wait_arm <= 1'b0;
    $display("test wait states done");
    wrap_up();
  end
endmodule // ext_data_access_stretch_wait_tb
